// >>> hw/capture_pkg.sv
package capture_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int TIMER_WIDTH = 12;
	localparam int CHANNELS = 4;

	// ==========================================================
	// register indices, byte address is four times the index
	localparam int ADDR_WIDTH = 12;
	localparam logic [7:0] IDX_A_RISE = 8'h40;
	localparam logic [7:0] IDX_A_FALL = 8'h41;
	localparam logic [7:0] IDX_B_RISE = 8'h42;
	localparam logic [7:0] IDX_B_FALL = 8'h43;
	localparam logic [7:0] IDX_CONFIG = 8'h44;
	localparam logic [7:0] IDX_FLAGS = 8'h45;
	localparam logic [7:0] IDX_FLAG_CLEAR = 8'h46;
	localparam logic [7:0] IDX_GLOBAL_IE = 8'h47;

	// ==========================================================
	// fields and reset values
	localparam int CH_A_RISE = 0;
	localparam int CH_A_FALL = 1;
	localparam int CH_B_RISE = 2;
	localparam int CH_B_FALL = 3;
	localparam int CFG_HOLD_BIT = 7;
	localparam int CFG_PRESCALE_LSB = 4;
	localparam int CFG_IE_LSB = 0;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [2:0] PRESCALE_MAX = 3'h4;

	// ==========================================================
	// bus phase
	typedef enum logic {PH_IDLE, PH_DONE} apb_phase_t;

endpackage : capture_pkg

// >>> hw/capture_timebase.sv
`timescale 1ns/1ns
module capture_timebase #(
	parameter int WIDTH = capture_pkg::TIMER_WIDTH,
	parameter int TICK_CYCLES = capture_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// free-running time
	output logic [WIDTH-1:0] timer_o
);

	localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

	logic [PW-1:0] pre;

	// ==========================================================
	// microsecond divider
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i || pre == PRE_LAST)
			pre <= '0;
		else
			pre <= pre + PW'(1);
	end

	// ==========================================================
	// counter wraps freely, nobody ever stops it
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			timer_o <= '0;
		else if (pre == PRE_LAST)
			timer_o <= timer_o + WIDTH'(1);
	end

endmodule : capture_timebase

// >>> hw/edge_capture_timer.sv
// How it works
// - status holds B fall bit3, B rise bit2, A fall bit1, A rise bit0.
// - a flag sets only on an edge matching its rising or falling condition.
// - reading a channel's data register clears that channel's flag.
// - each channel keeps its captured time in an 8-bit read-only register.
// - with hold set, first edge time is kept and later edges ignored until read or its flag is cleared.
// - with hold clear, every edge overwrites the stored time.
// - one hold bit governs all four channels together.
// - prescale field picks timer slice 7:0 up to 11:4.
// - finest slice steps one microsecond, each code doubles step and range.
// - config bits 3 to 0 enable each event's interrupt, reset off.
// - both pin A events share one request, both pin B events another.
// - a capture request also needs the main capture interrupt enable.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
module edge_capture_timer #(
	parameter int TIMER_WIDTH = capture_pkg::TIMER_WIDTH,
	parameter int TICK_CYCLES = capture_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RESET_I,
	// apb slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [capture_pkg::ADDR_WIDTH-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// capture pins
	input wire logic CAP_A_I,
	input wire logic CAP_B_I,
	// interrupt requests
	output logic IRQ_A_O,
	output logic IRQ_B_O,
	output logic IRQ_O
);

	// ==========================================================
	// declarations
	capture_pkg::apb_phase_t phase;
	logic [TIMER_WIDTH-1:0] timer;
	logic [7:0] cfg;
	logic gie;
	logic [1:0] pin_prev;
	logic primed;
	logic [3:0] flags;
	logic [7:0] cap_data [capture_pkg::CHANNELS];
	logic [3:0] edge_now;
	logic [3:0] clear_now;
	logic [7:0] slice;
	logic [7:0] next_rdata;
	logic xfer_done;
	logic rd_done;
	logic wr_done;
	logic [7:0] idx;
	logic hold;
	logic [2:0] prescale;
	logic latch_now;
	logic [3:0] irq_en;

	// ==========================================================
	// decode helpers
	function automatic logic [7:0] reg_index(input logic [capture_pkg::ADDR_WIDTH-1:0] a);
		return a[9:2];
	endfunction : reg_index

	function automatic logic reg_mapped(input logic [capture_pkg::ADDR_WIDTH-1:0] a);
		logic [7:0] i;
		i = reg_index(a);
		return (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
			(i >= capture_pkg::IDX_A_RISE) && (i <= capture_pkg::IDX_GLOBAL_IE);
	endfunction : reg_mapped

	// one decode for every write and read-clear hit; the read data mux decodes the index alone
	function automatic logic reg_hit(input logic [capture_pkg::ADDR_WIDTH-1:0] a,
		input logic [7:0] target);
		return reg_mapped(a) && (reg_index(a) == target);
	endfunction : reg_hit

	function automatic logic request(input logic [3:0] f, input logic [3:0] en, input logic g);
		return g && (|(f & en));
	endfunction : request

	function automatic logic [7:0] timer_slice(input logic [2:0] code,
		input logic [TIMER_WIDTH-1:0] t);
		logic [7:0] s;
		s = capture_pkg::DATA_RESET;
		unique case (code)
			3'h0: s = t[7:0];
			3'h1: s = t[8:1];
			3'h2: s = t[9:2];
			3'h3: s = t[10:3];
			3'h4: s = t[11:4];
			default: s = capture_pkg::DATA_RESET;
		endcase
		return s;
	endfunction : timer_slice

	// ==========================================================
	// microsecond time base
	capture_timebase #(
		.WIDTH(TIMER_WIDTH),
		.TICK_CYCLES(TICK_CYCLES)
	) u_timebase (
		.clk_sys_i(CLK_SYS_I),
		.reset_i(RESET_I),
		.timer_o(timer)
	);

	// ==========================================================
	// apb handshake: one wait state, read data latched first
	assign idx = reg_index(PADDR_I);
	assign xfer_done = (phase == capture_pkg::PH_DONE) && PSEL_I && PENABLE_I;
	assign rd_done = xfer_done && !PWRITE_I;
	assign wr_done = xfer_done && PWRITE_I;
	assign PREADY_O = (phase == capture_pkg::PH_DONE);
	assign latch_now = (phase == capture_pkg::PH_IDLE) && PSEL_I && PENABLE_I;

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RESET_I)
			phase <= capture_pkg::PH_IDLE;
		else
		begin
			unique case (phase)
				capture_pkg::PH_IDLE:
					if (PSEL_I && PENABLE_I)
						phase <= capture_pkg::PH_DONE;
				capture_pkg::PH_DONE:
					phase <= capture_pkg::PH_IDLE;
			endcase
		end
	end

	always_comb
	begin
		next_rdata = 8'h00;
		unique case (idx)
			capture_pkg::IDX_A_RISE: next_rdata = cap_data[capture_pkg::CH_A_RISE];
			capture_pkg::IDX_A_FALL: next_rdata = cap_data[capture_pkg::CH_A_FALL];
			capture_pkg::IDX_B_RISE: next_rdata = cap_data[capture_pkg::CH_B_RISE];
			capture_pkg::IDX_B_FALL: next_rdata = cap_data[capture_pkg::CH_B_FALL];
			capture_pkg::IDX_CONFIG: next_rdata = cfg;
			capture_pkg::IDX_FLAGS: next_rdata = {4'h0, flags};
			capture_pkg::IDX_GLOBAL_IE: next_rdata = {7'h00, gie};
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RESET_I)
			PRDATA_O <= 32'h00000000;
		else if (latch_now)
			PRDATA_O <= PWRITE_I ? 32'h00000000 : {24'h000000, next_rdata};
	end

	// an unmapped access still completes, only flagged, and changes nothing
	always_ff @(posedge CLK_SYS_I)
	begin
		if (RESET_I)
			PSLVERR_O <= 1'b0;
		else if (latch_now)
			PSLVERR_O <= !reg_mapped(PADDR_I);
	end

	// ==========================================================
	// software registers
	always_ff @(posedge CLK_SYS_I)
	begin
		if (RESET_I)
			cfg <= capture_pkg::CONFIG_RESET;
		else if (wr_done && reg_hit(PADDR_I, capture_pkg::IDX_CONFIG))
			cfg <= PWDATA_I[7:0];
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RESET_I)
			gie <= 1'b0;
		else if (wr_done && reg_hit(PADDR_I, capture_pkg::IDX_GLOBAL_IE))
			gie <= PWDATA_I[0];
	end

	assign hold = cfg[capture_pkg::CFG_HOLD_BIT];
	assign prescale = cfg[capture_pkg::CFG_PRESCALE_LSB +: 3];
	assign slice = timer_slice(prescale, timer);

	// ==========================================================
	// edge detection; pins arrive synchronous, first cycle after
	// reset only primes the history so a high pin is no edge
	always_ff @(posedge CLK_SYS_I)
	begin
		if (RESET_I)
			pin_prev <= 2'h0;
		else
			pin_prev <= {CAP_B_I, CAP_A_I};
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RESET_I)
			primed <= 1'b0;
		else
			primed <= 1'b1;
	end

	always_comb
	begin
		edge_now = 4'h0;
		if (primed)
		begin
			edge_now[capture_pkg::CH_A_RISE] = CAP_A_I && !pin_prev[0];
			edge_now[capture_pkg::CH_A_FALL] = !CAP_A_I && pin_prev[0];
			edge_now[capture_pkg::CH_B_RISE] = CAP_B_I && !pin_prev[1];
			edge_now[capture_pkg::CH_B_FALL] = !CAP_B_I && pin_prev[1];
		end
	end

	// ==========================================================
	// per-channel capture; a data read and a clear-register write
	// both clear, a simultaneous edge wins over either
	generate
		for (genvar ch = 0; ch < capture_pkg::CHANNELS; ch++)
		begin : g_chan
			logic flag_q;
			logic [7:0] data_q;
			logic accept;
			logic stale_q;

			assign clear_now[ch] = (rd_done && !stale_q &&
				reg_hit(PADDR_I, capture_pkg::IDX_A_RISE + 8'(ch))) ||
				(wr_done && PWDATA_I[ch] &&
				reg_hit(PADDR_I, capture_pkg::IDX_FLAG_CLEAR));
			// a held channel frees up in the very cycle it is read
			assign accept = edge_now[ch] && !(hold && flag_q && !clear_now[ch]);

			// an edge taken while a read latches its data is not in that data,
			// so the completing read leaves the flag up instead of losing the event
			always_ff @(posedge CLK_SYS_I)
			begin
				if (RESET_I)
					stale_q <= 1'b0;
				else
					stale_q <= latch_now && accept;
			end

			always_ff @(posedge CLK_SYS_I)
			begin
				if (RESET_I)
					data_q <= capture_pkg::DATA_RESET;
				else if (accept)
					data_q <= slice;
			end

			always_ff @(posedge CLK_SYS_I)
			begin
				if (RESET_I)
					flag_q <= 1'b0;
				else if (accept)
					flag_q <= 1'b1;
				else if (clear_now[ch])
					flag_q <= 1'b0;
			end

			assign flags[ch] = flag_q;
			assign cap_data[ch] = data_q;
		end
	endgenerate

	// ==========================================================
	// interrupts; a pin's request says only that one of its two
	// events fired, software reads both flags to tell which
	assign irq_en = cfg[capture_pkg::CFG_IE_LSB +: 4];

	// registered so a request never glitches while flags and masks move together
	always_ff @(posedge CLK_SYS_I)
	begin
		if (RESET_I)
			IRQ_A_O <= 1'b0;
		else
			IRQ_A_O <= request({2'h0, flags[1:0]}, irq_en, gie);
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RESET_I)
			IRQ_B_O <= 1'b0;
		else
			IRQ_B_O <= request({flags[3:2], 2'h0}, irq_en, gie);
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RESET_I)
			IRQ_O <= 1'b0;
		else
			IRQ_O <= request(flags, irq_en, gie);
	end

endmodule : edge_capture_timer

// >>> testbench/cap_pin_model.sv
`timescale 1ns/1ns
// ==========================================================
// capture pin source
module cap_pin_model (
	// clock
	input wire logic clk_i,
	// requested levels
	input wire logic a_i,
	input wire logic b_i,
	// pins, moved only just after a rising edge so levels are clean
	output logic cap_a_o = 1'b0,
	output logic cap_b_o = 1'b0
);
	always @(posedge clk_i)
	begin
		cap_a_o <= a_i;
		cap_b_o <= b_i;
	end
endmodule : cap_pin_model

// >>> testbench/edge_capture_timer_sva.sv
`timescale 1ns/1ns
// ==========================================================
// port checker
module edge_capture_timer_chk (
	// clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RESET_I,
	// apb
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic [capture_pkg::ADDR_WIDTH-1:0] PADDR_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	// interrupts
	input wire logic IRQ_A_O,
	input wire logic IRQ_B_O,
	input wire logic IRQ_O
);
	default clocking @(posedge CLK_SYS_I);
	endclocking
	default disable iff (RESET_I);
	logic mapped;
	assign mapped = PADDR_I[1:0] == 2'h0 && PADDR_I[11:2] >= 10'h40 && PADDR_I[11:2] <= 10'h47;
	sequence setup_s;
		PSEL_I && !PENABLE_I;
	endsequence
	sequence access_s;
		PSEL_I && PENABLE_I;
	endsequence
	wait_state_a: assert property (setup_s ##1 access_s |-> !PREADY_O ##1 PREADY_O)
		else $error("ready not after one wait state");
	ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready longer than one cycle");
	ready_access_a: assert property (PREADY_O |-> access_s)
		else $error("ready outside access phase");
	byte_data_a: assert property (PREADY_O |-> PRDATA_O[31:8] == 24'h0)
		else $error("read data wider than a byte");
	bad_addr_a: assert property (PREADY_O |-> PSLVERR_O == !mapped)
		else $error("error response wrong for address");
	irq_merge_a: assert property (IRQ_O == (IRQ_A_O || IRQ_B_O))
		else $error("combined request not merge of pins");
	irq_fall_a: assert property ($fell(IRQ_O) |-> $past(PREADY_O, 2))
		else $error("request dropped without a bus access");
	reset_quiet_a: assert property (disable iff (1'b0) RESET_I |=> !PREADY_O && !IRQ_O)
		else $error("outputs active after reset");
endmodule : edge_capture_timer_chk

bind edge_capture_timer edge_capture_timer_chk u_chk (.CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I),
	.PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .IRQ_A_O(IRQ_A_O), .IRQ_B_O(IRQ_B_O),
	.IRQ_O(IRQ_O));

// >>> testbench/tb_edge_capture_timer.sv
`timescale 1ns/1ns
// ==========================================================
// bench, timer tick shortened so wide prescales stay quick
module tb_edge_capture_timer;
	localparam int TK = 2;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, a = 0, b = 0;
	logic [11:0] padr = 0;
	logic [31:0] pwd = 0, q, r, rdat;
	logic [32:0] e;
	logic [7:0] ri, fi;
	logic [7:0] cfg[4] = '{8'h80, 8'h00, 8'h40, 8'h50};
	wire logic cap_a, cap_b, rdy, err, ia, ib, irq;
	int miscompares = 0, checks_done = 0, n, m, w;
	logic [32:0] eq[$];
	bit mq[$];
	bit [31:0] s = 32'h384D904A;
	always #50 clk = ~clk;
	cap_pin_model u_pins (.clk_i(clk), .a_i(a), .b_i(b), .cap_a_o(cap_a), .cap_b_o(cap_b));
	edge_capture_timer #(.TICK_CYCLES(TK)) u_dut (.CLK_SYS_I(clk), .RESET_I(rst),
		.PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
		.PRDATA_O(rdat), .PREADY_O(rdy), .PSLVERR_O(err), .CAP_A_I(cap_a), .CAP_B_I(cap_b),
		.IRQ_A_O(ia), .IRQ_B_O(ib), .IRQ_O(irq));
	function int rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s[3:0] + 1;
	endfunction : rnd
	task chk(input string nm, input logic [32:0] seen, input logic [32:0] ex);
		checks_done++;
		if (seen !== ex)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
		end
	endtask : chk
	// ==========================================================
	// apb master, expected read results go to the queue
	task apb(input bit is_wr, input logic [11:0] ad, input logic [31:0] d, input logic [32:0] ex,
		input bit k);
		if (!is_wr)
		begin
			eq.push_back(ex);
			mq.push_back(k);
		end
		@(posedge clk);
		psel <= 1;
		pen <= 0;
		pwr <= is_wr;
		padr <= ad;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		@(posedge clk);
		while (rdy !== 1'b1) @(posedge clk);
		q = rdat;
		psel <= 0;
		pen <= 0;
	endtask : apb
	task rd(input logic [7:0] i, input logic [7:0] ex, input bit k);
		apb(0, {2'h0, i, 2'h0}, 0, {25'h0, ex}, k);
	endtask : rd
	task wr(input logic [7:0] i, input logic [7:0] d);
		apb(1, {2'h0, i, 2'h0}, {24'h0, d}, 0, 0);
	endtask : wr
	task pulse(input bit p, input int wd);
		@(posedge clk);
		if (p) b <= 1; else a <= 1;
		repeat (wd) @(posedge clk);
		if (p) b <= 0; else a <= 0;
		repeat (4) @(posedge clk);
	endtask : pulse
	task idle;
		repeat (3) @(negedge clk);
	endtask : idle
	always @(posedge clk)
		if (psel && pen && rdy === 1'b1 && !pwr && mq.size() > 0)
		begin
			e = eq.pop_front();
			if (mq.pop_front()) chk("read", {err, rdat}, e);
		end
	task summarize;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		summarize;
	end
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 0;
		for (int i = 'h40; i < 'h46; i++) rd(8'(i), 0, 1);
		apb(0, 12'h200, 0, {1'b1, 32'h0}, 1);
		wr(capture_pkg::IDX_A_FALL, 8'hFF);
		rd(capture_pkg::IDX_A_FALL, 0, 1);
		// hold, latest, widest slice, reserved code, on both pins
		for (int p = 0; p < 2; p++)
			for (int md = 0; md < 4; md++)
			begin
				n = rnd();
				m = rnd();
				w = (md == 2) ? 16 * TK : TK;
				ri = p ? capture_pkg::IDX_B_RISE : capture_pkg::IDX_A_RISE;
				fi = p ? capture_pkg::IDX_B_FALL : capture_pkg::IDX_A_FALL;
				wr(capture_pkg::IDX_CONFIG, cfg[md]);
				pulse(p[0], n * w);
				pulse(p[0], m * w);
				rd(ri, 0, md == 3);
				r = q;
				rd(fi, md == 3 ? 8'h0 : 8'(r + (md == 0 ? n : m)), 1);
				rd(capture_pkg::IDX_FLAGS, 0, 1);
			end
		wr(capture_pkg::IDX_CONFIG, 8'h01);
		pulse(0, 3);
		idle;
		chk("irq", irq, 0);
		wr(capture_pkg::IDX_GLOBAL_IE, 8'h01);
		idle;
		chk("irq pins", {ia, ib}, 2'b10);
		rd(capture_pkg::IDX_FLAGS, 8'h03, 1);
		wr(capture_pkg::IDX_CONFIG, 8'h00);
		idle;
		chk("irq masked", irq, 0);
		wr(capture_pkg::IDX_CONFIG, 8'h01);
		idle;
		chk("irq unmasked", irq, 1);
		wr(capture_pkg::IDX_FLAG_CLEAR, 8'h01);
		idle;
		chk("irq cleared", irq, 0);
		rd(capture_pkg::IDX_FLAGS, 8'h02, 1);
		rd(capture_pkg::IDX_A_FALL, 0, 0);
		rd(capture_pkg::IDX_FLAGS, 8'h00, 1);
		wr(capture_pkg::IDX_CONFIG, 8'h08);
		pulse(1, 3);
		idle;
		chk("irq b", {ia, ib, irq}, 3'b011);
		rd(capture_pkg::IDX_FLAGS, 8'h0C, 1);
		rd(capture_pkg::IDX_CONFIG, 8'h08, 1);
		summarize;
	end
endmodule : tb_edge_capture_timer
